// ==== fbid_params.svh ====
// Constants for the full bridge input decoder
`ifndef FBID_PARAMS_SVH
`define FBID_PARAMS_SVH
`define FBID_CLK_MHZ         125
`define FBID_RES_PULSE_US    10
`define FBID_RES_CYC         (`FBID_RES_PULSE_US * `FBID_CLK_MHZ)
`define FBID_CP_SETTLE_US    3000
`define FBID_CP_CYC          (`FBID_CP_SETTLE_US * `FBID_CLK_MHZ)
`define FBID_DEAD_DEF_US     6
`define FBID_DEAD_DEF_CYC    (`FBID_DEAD_DEF_US * `FBID_CLK_MHZ)
`define FBID_DEAD_W          12
`define FBID_TMR_W           20
`define FBID_ADDR_CTRL       12'h000
`define FBID_ADDR_STAT       12'h004
`define FBID_ADDR_DEAD       12'h008
`define FBID_CTRL_DTEN       0
`define FBID_CTRL_DTDEF      1
`define FBID_STAT_GATES      3:0
`define FBID_STAT_AWAKE      4
`define FBID_STAT_FAULT      5
`define FBID_STAT_SLEEP      6
`define FBID_CTRL_RST        2'h0
`define FBID_DEAD_RST        12'h07d
`endif

// ==== fbid_pkg.sv ====
// Types for the full bridge input decoder
package fbid_pkg;
  typedef enum logic [1:0] {FBID_SLEEP, FBID_WAKE, FBID_RUN} fbid_pwr_t;
endpackage : fbid_pkg

// ==== fbid_decoder.sv ====
// Full bridge input decoder with sleep, fault clear and dead time
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`include "fbid_params.svh"
module fbid_decoder
  import fbid_pkg::*;
#(
  parameter int RES_CYC  = `FBID_RES_CYC,
  parameter int CP_CYC   = `FBID_CP_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        highChopIn,
  input  wire logic        lowChopIn,
  input  wire logic        directionIn,
  input  wire logic        syncRectifyEn,
  input  wire logic        resetInN,
  input  wire logic        pumpReady,
  input  wire logic        faultDetect,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             leftUpperGate,
  output logic             leftLowerGate,
  output logic             rightUpperGate,
  output logic             rightLowerGate,
  output logic             faultLatched,
  output logic             sleepOut
);

  // Gate request decode: {lu, ll, ru, rl}
  function automatic logic [3:0] decode(input logic h, input logic l,
                                        input logic d, input logic s);
    logic [3:0] g;
    g = 4'h0;
    if (h && l) begin
      g = d ? 4'b1001 : 4'b0110;
    end else if (!h && l) begin
      g = s ? 4'b0101 : (d ? 4'b0001 : 4'b0100);
    end else if (h && !l) begin
      g = s ? 4'b1010 : (d ? 4'b1000 : 4'b0010);
    end
    return g;
  endfunction : decode

  logic [1:0] hSync_q, lSync_q, dSync_q, sSync_q, rSync_q;
  logic [1:0] ctrl_q;
  logic [`FBID_DEAD_W-1:0] dead_q;
  logic [`FBID_TMR_W-1:0] resCnt_q, cpCnt_q;
  logic [`FBID_DEAD_W-1:0] dtL_q, dtR_q;
  fbid_pwr_t pwr_q;
  logic [3:0] want;
  logic [`FBID_DEAD_W-1:0] deadCyc;
  logic [`FBID_DEAD_W-1:0] deadLoad;
  logic rstLow, pumpSync;
  logic [1:0] pSync_q;
  logic [1:0] fSync_q;

  // Two-stage synchronisers for all pins except nrst and the APB inputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hSync_q <= 2'h0;
      lSync_q <= 2'h0;
      dSync_q <= 2'h0;
      sSync_q <= 2'h0;
      rSync_q <= 2'h0;
      pSync_q <= 2'h0;
      fSync_q <= 2'h0;
    end else begin
      hSync_q <= {hSync_q[0], highChopIn};
      lSync_q <= {lSync_q[0], lowChopIn};
      dSync_q <= {dSync_q[0], directionIn};
      sSync_q <= {sSync_q[0], syncRectifyEn};
      rSync_q <= {rSync_q[0], resetInN};
      pSync_q <= {pSync_q[0], pumpReady};
      fSync_q <= {fSync_q[0], faultDetect};
    end
  end

  assign rstLow   = !rSync_q[1];
  assign pumpSync = pSync_q[1];
  assign want     = decode(hSync_q[1], lSync_q[1], dSync_q[1], sSync_q[1]);
  assign deadCyc  = ctrl_q[`FBID_CTRL_DTDEF] ? `FBID_DEAD_W'(`FBID_DEAD_DEF_CYC) : dead_q;
  assign deadLoad = ctrl_q[`FBID_CTRL_DTEN] ? deadCyc : '0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resCnt_q <= '0;
    end else if (!rstLow) begin
      resCnt_q <= '0;
    end else if (resCnt_q != `FBID_TMR_W'(RES_CYC)) begin
      resCnt_q <= resCnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwr_q   <= FBID_WAKE;
      cpCnt_q <= '0;
    end else begin
      unique case (pwr_q)
        FBID_RUN: begin
          if (rstLow && resCnt_q == `FBID_TMR_W'(RES_CYC)) begin
            pwr_q <= FBID_SLEEP;
          end
        end
        FBID_SLEEP: begin
          cpCnt_q <= '0;
          if (!rstLow) begin
            pwr_q <= FBID_WAKE;
          end
        end
        FBID_WAKE: begin
          if (rstLow && resCnt_q == `FBID_TMR_W'(RES_CYC)) begin
            pwr_q <= FBID_SLEEP;
          end else if (pumpSync || cpCnt_q == `FBID_TMR_W'(CP_CYC)) begin
            pwr_q <= FBID_RUN;
          end else begin
            cpCnt_q <= cpCnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // fault latch, set wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      faultLatched <= 1'b0;
    end else if (fSync_q[1] && pwr_q == FBID_RUN) begin
      faultLatched <= 1'b1;
    end else if (rstLow) begin
      faultLatched <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sleepOut <= 1'b1;
    end else begin
      sleepOut <= (pwr_q == FBID_SLEEP);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      leftUpperGate  <= 1'b0;
      leftLowerGate  <= 1'b0;
      rightUpperGate <= 1'b0;
      rightLowerGate <= 1'b0;
      dtL_q          <= '0;
      dtR_q          <= '0;
    end else if (pwr_q != FBID_RUN || faultLatched || rstLow) begin
      leftUpperGate  <= 1'b0;
      leftLowerGate  <= 1'b0;
      rightUpperGate <= 1'b0;
      rightLowerGate <= 1'b0;
      dtL_q          <= deadLoad;
      dtR_q          <= deadLoad;
    end else begin
      // Any turn-off starts the dead count, so a pass through coast is guarded too
      if ((leftUpperGate && !want[3]) || (leftLowerGate && !want[2])) begin
        leftUpperGate <= 1'b0;
        leftLowerGate <= 1'b0;
        dtL_q         <= deadLoad;
      end else if (dtL_q != '0) begin
        dtL_q         <= dtL_q - 1'b1;
        leftUpperGate <= 1'b0;
        leftLowerGate <= 1'b0;
      end else begin
        leftUpperGate <= want[3];
        leftLowerGate <= want[2];
      end
      if ((rightUpperGate && !want[1]) || (rightLowerGate && !want[0])) begin
        rightUpperGate <= 1'b0;
        rightLowerGate <= 1'b0;
        dtR_q          <= deadLoad;
      end else if (dtR_q != '0) begin
        dtR_q          <= dtR_q - 1'b1;
        rightUpperGate <= 1'b0;
        rightLowerGate <= 1'b0;
      end else begin
        rightUpperGate <= want[1];
        rightLowerGate <= want[0];
      end
    end
  end

  // APB slave, zero wait states
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `FBID_CTRL_RST;
      dead_q <= `FBID_DEAD_RST;
    end else if (psel && penable && pwrite) begin
      if (paddr == `FBID_ADDR_CTRL) begin
        ctrl_q <= pwdata[1:0];
      end else if (paddr == `FBID_ADDR_DEAD) begin
        dead_q <= pwdata[`FBID_DEAD_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        unique case (paddr)
          `FBID_ADDR_CTRL: prdata <= {30'h0, ctrl_q};
          `FBID_ADDR_STAT: prdata <= {25'h0, pwr_q == FBID_SLEEP, faultLatched,
                                      pwr_q == FBID_RUN, leftUpperGate, leftLowerGate,
                                      rightUpperGate, rightLowerGate};
          `FBID_ADDR_DEAD: prdata <= {20'h0, dead_q};
          default:         pslverr <= 1'b1;
        endcase
      end
    end
  end

  AST_LEFT_INTERLOCK: assert property (@(posedge clk) disable iff (!nrst)
    !(leftUpperGate && leftLowerGate)) else $error("left leg shoot-through");
  AST_RIGHT_INTERLOCK: assert property (@(posedge clk) disable iff (!nrst)
    !(rightUpperGate && rightLowerGate)) else $error("right leg shoot-through");
  AST_COAST: assert property (@(posedge clk) disable iff (!nrst)
    (!hSync_q[1] && !lSync_q[1]) |=> !(leftUpperGate || leftLowerGate
      || rightUpperGate || rightLowerGate)) else $error("coast not honoured");
  AST_SLEEP_OFF: assert property (@(posedge clk) disable iff (!nrst)
    pwr_q == FBID_SLEEP |=> !(leftUpperGate || leftLowerGate || rightUpperGate
      || rightLowerGate)) else $error("gate on in sleep");
  AST_WAKE_OFF: assert property (@(posedge clk) disable iff (!nrst)
    pwr_q == FBID_WAKE |=> !(leftUpperGate || leftLowerGate || rightUpperGate
      || rightLowerGate)) else $error("gate on in wake");
  AST_FAULT_CLR: assert property (@(posedge clk) disable iff (!nrst)
    (pwr_q == FBID_SLEEP && !fSync_q[1]) |=> !faultLatched) else $error("fault kept in sleep");
  AST_SHORT_PULSE: assert property (@(posedge clk) disable iff (!nrst)
    (pwr_q == FBID_RUN && resCnt_q < `FBID_TMR_W'(RES_CYC)) |=> pwr_q != FBID_SLEEP)
    else $error("early sleep");
  AST_FULL_DRIVE: assert property (@(posedge clk) disable iff (!nrst)
    (pwr_q == FBID_RUN && !faultLatched && !rstLow && want == 4'b1001 && leftUpperGate
     && rightLowerGate) |=> leftUpperGate || $changed(want)) else $error("drive dropped");
  AST_REVERSE: assert property (@(posedge clk) disable iff (!nrst)
    (hSync_q[1] && lSync_q[1] && !dSync_q[1]) |-> want == 4'b0110)
    else $error("reverse drive decode wrong");
  AST_LOW_BRAKE: assert property (@(posedge clk) disable iff (!nrst)
    (!hSync_q[1] && lSync_q[1] && sSync_q[1]) |-> want == 4'b0101)
    else $error("low brake decode wrong");
  AST_HIGH_BRAKE: assert property (@(posedge clk) disable iff (!nrst)
    (hSync_q[1] && !lSync_q[1] && sSync_q[1]) |-> want == 4'b1010)
    else $error("high brake decode wrong");
  AST_LOW_DIODE: assert property (@(posedge clk) disable iff (!nrst)
    (!hSync_q[1] && lSync_q[1] && !sSync_q[1]) |-> want == (dSync_q[1] ? 4'b0001 : 4'b0100))
    else $error("low diode decode wrong");
  AST_HIGH_DIODE: assert property (@(posedge clk) disable iff (!nrst)
    (hSync_q[1] && !lSync_q[1] && !sSync_q[1]) |-> want == (dSync_q[1] ? 4'b1000 : 4'b0010))
    else $error("high diode decode wrong");
  AST_RECTIFY: assert property (@(posedge clk) disable iff (!nrst)
    (want == 4'b0101 || want == 4'b1010) |-> sSync_q[1] && (hSync_q[1] != lSync_q[1]))
    else $error("rectify outside off time");
  AST_DEAD_LEFT: assert property (@(posedge clk) disable iff (!nrst)
    (dtL_q != '0) |-> !(leftUpperGate || leftLowerGate))
    else $error("left gate on in dead time");
  AST_DEAD_RIGHT: assert property (@(posedge clk) disable iff (!nrst)
    (dtR_q != '0) |-> !(rightUpperGate || rightLowerGate))
    else $error("right gate on in dead time");
  AST_FAULT_OFF: assert property (@(posedge clk) disable iff (!nrst)
    faultLatched |=> !(leftUpperGate || leftLowerGate || rightUpperGate
      || rightLowerGate))
    else $error("gate on with fault latched");
  COV_SLEEP: cover property (@(posedge clk) pwr_q == FBID_SLEEP ##1 pwr_q == FBID_WAKE);
  COV_RUN: cover property (@(posedge clk) pwr_q == FBID_WAKE ##1 pwr_q == FBID_RUN);
  COV_BRAKE: cover property (@(posedge clk) leftLowerGate && rightLowerGate);
  COV_DEAD: cover property (@(posedge clk) dtL_q != '0 ##1 dtL_q == '0);
endmodule : fbid_decoder

// ==== fbid_host.sv ====
// Host model driving the bridge control pins
`timescale 1ns/1ps
module fbid_host (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [3:0] cmdIn,
  input  wire logic       quadMode,
  output logic            highChopIn,
  output logic            lowChopIn,
  output logic            directionIn,
  output logic            syncRectifyEn
);
  logic [3:0] pwmCnt_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwmCnt_q <= 4'h0;
    end else begin
      pwmCnt_q <= pwmCnt_q + 4'h1;
    end
  end
  // Slow period so a leg swap settles before the next one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {highChopIn, lowChopIn, directionIn, syncRectifyEn} <= 4'h0;
    end else if (quadMode) begin
      {highChopIn, lowChopIn, syncRectifyEn} <= 3'h7;
      directionIn <= pwmCnt_q[3];
    end else begin
      {highChopIn, lowChopIn, directionIn, syncRectifyEn} <= cmdIn;
    end
  end
endmodule : fbid_host

// ==== tb.sv ====
// Self-checking bench for the full bridge input decoder
`timescale 1ns/1ps
module tb
  import fbid_pkg::*;
;
  logic        clk, nrst, resetInN, pumpReady, faultDetect, quad;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  cmd;
  logic        hc, lc, dc, sr, lu, ll, ru, rl, flt, slp, er;
  int          badCount, nCompared;
  wire  [3:0]  gates = {lu, ll, ru, rl};
  localparam logic [63:0] TBL = 64'h9966a8a251540000;
  fbid_host i_fbid_host (.clk(clk), .nrst(nrst), .cmdIn(cmd), .quadMode(quad),
    .highChopIn(hc), .lowChopIn(lc), .directionIn(dc), .syncRectifyEn(sr));
  fbid_decoder #(.RES_CYC(20), .CP_CYC(50)) i_fbid_decoder (.clk(clk), .nrst(nrst),
    .highChopIn(hc), .lowChopIn(lc), .directionIn(dc), .syncRectifyEn(sr),
    .resetInN(resetInN), .pumpReady(pumpReady), .faultDetect(faultDetect),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .leftUpperGate(lu),
    .leftLowerGate(ll), .rightUpperGate(ru), .rightLowerGate(rl),
    .faultLatched(flt), .sleepOut(slp));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic giveVerdict();
    if (badCount == 0 && nCompared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : giveVerdict
  // No half-bridge ever sees both gates on
  always @(posedge clk) if (nrst) check("shoot", (lu & ll) | (ru & rl), 0);
  task automatic t_wake();
    apb(1'b0, 12'h000, 0);
    check("ctrl", rd, 0);
    apb(1'b0, 12'h008, 0);
    check("dead", rd, 32'h7d);
    apb(1'b0, 12'h00c, 0);
    check("slverr", er, 1);
    cmd <= 4'he;
    wt(20);
    check("wake", gates, 0);
    pumpReady <= 1'b1;
    wt(10);
    check("run", gates, 4'h9);
    apb(1'b0, 12'h004, 0);
    check("stat", rd[6:0], 7'h19);
  endtask : t_wake
  task automatic t_table();
    for (int i = 0; i < 16; i++) begin
      cmd <= i[3:0];
      wt(8);
      check("table", gates, TBL[i*4+:4]);
    end
  endtask : t_table
  task automatic t_dead();
    apb(1'b1, 12'h008, 32'h8);
    apb(1'b1, 12'h000, 32'h1);
    cmd <= 4'he;
    wt(20);
    cmd <= 4'hc;
    wt(6);
    check("dead_off", gates, 0);
    wt(20);
    check("dead_on", gates, 4'h6);
    apb(1'b1, 12'h000, 32'h3);
    cmd <= 4'he;
    wt(700);
    check("def_off", gates, 0);
    wt(100);
    check("def_on", gates, 4'h9);
    apb(1'b1, 12'h000, 32'h0);
  endtask : t_dead
  task automatic t_reset();
    faultDetect <= 1'b1;
    wt(2);
    faultDetect <= 1'b0;
    wt(6);
    check("flt", {flt, gates}, 5'h10);
    resetInN <= 1'b0;
    wt(5);
    resetInN <= 1'b1;
    wt(8);
    check("clear", {slp, flt, gates}, 6'h09);
    faultDetect <= 1'b1;
    wt(2);
    faultDetect <= 1'b0;
    resetInN <= 1'b0;
    wt(30);
    check("sleep", {slp, flt, gates}, 6'h20);
    pumpReady <= 1'b0;
    resetInN <= 1'b1;
    wt(20);
    check("rewake", {slp, gates}, 5'h00);
    wt(50);
    check("pump_timeout", {slp, gates}, 5'h09);
  endtask : t_reset
  task automatic t_quad();
    int a, b;
    a = 0;
    b = 0;
    quad <= 1'b1;
    repeat (64) begin
      @(posedge clk);
      a += (gates === 4'h9);
      b += (gates === 4'h6);
    end
    check("quad", (a > 16) && (b > 16), 1);
    quad <= 1'b0;
  endtask : t_quad
  initial begin
    #60000;
    badCount++;
    giveVerdict();
  end
  initial begin
    {nrst, resetInN, pumpReady, faultDetect, quad} = 5'h08;
    {psel, penable, pwrite, paddr, pwdata, cmd} = 0;
    badCount = 0;
    nCompared = 0;
    wt(4);
    nrst <= 1'b1;
    @(posedge clk);
    t_wake();
    t_table();
    t_dead();
    t_reset();
    t_quad();
    giveVerdict();
  end
endmodule : tb
